// ### hw/seg_decode_pkg.sv
package seg_decode_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_SPACE  = 4'h4;
  localparam logic [3:0] OFS_CONFIG = 4'h8;
  localparam logic [3:0] OFS_RESULT = 4'hC;

  // Status register field positions
  localparam int POS_EXL   = 1;
  localparam int POS_ERL   = 2;
  localparam int POS_PRIV  = 3;
  localparam int POS_SWIDE = 5;
  localparam int POS_KWIDE = 7;

  // Reset values
  localparam logic [1:0] RST_PRIV  = 2'h0;
  localparam logic       RST_EXL   = 1'b0;
  localparam logic       RST_ERL   = 1'b1;
  localparam logic       RST_SWIDE = 1'b0;
  localparam logic       RST_KWIDE = 1'b0;
  localparam logic [7:0] RST_SPACE = 8'h00;
  localparam logic [2:0] RST_K0    = 3'h2;

  // Privilege level field codes
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_SUPER  = 2'h1;
  localparam logic [1:0] PRIV_USER   = 2'h2;

  // Cache attribute meaning uncached
  localparam logic [2:0] CACHE_UNCACHED = 3'h2;

  // Fixed address patterns
  localparam logic [31:0] DIRECT_CACHED_KERNEL_SEGMENT_BASE   = 32'h8000_0000;
  localparam logic [31:0] UNCACHED_DIRECT_KERNEL_SEGMENT_BASE   = 32'hA000_0000;
  localparam logic [9:0]  DEBUG_TOP10  = 10'h3FC;
  localparam logic [34:0] CSSEG_TOP35  = 35'h7_FFFF_FFFE;
  localparam logic [31:0] ONES32       = 32'hFFFF_FFFF;

  typedef enum logic [3:0] {
    SEG_NONE   = 4'b0000,
    SEG_SUSEG  = 4'b0001,
    SEG_SSEG   = 4'b0010,
    SEG_XSUSEG = 4'b0011,
    SEG_XSSEG  = 4'b0100,
    SEG_CSSEG  = 4'b0101,
    SEG_KUSEG  = 4'b0110,
    SEG_KDIRC  = 4'b0111,
    SEG_KDIRU  = 4'b1000,
    SEG_KSSEG  = 4'b1001,
    SEG_KMAP   = 4'b1010,
    SEG_DEBUG  = 4'b1011,
    SEG_XKPHYS = 4'b1100,
    SEG_XKMAP  = 4'b1101,
    SEG_USEG   = 4'b1110
  } segment_e;

  typedef enum logic [1:0] {
    MODE_KERNEL = 2'b00,
    MODE_SUPER  = 2'b01,
    MODE_USER   = 2'b10
  } mode_e;

  typedef struct packed {
    logic        valid;
    logic [63:0] vaddr;
  } xlate_req_s;

  typedef struct packed {
    logic        valid;
    logic        addr_error;
    logic        mapped;
    logic        wide_refill;
    logic        cache_from_tlb;
    logic [2:0]  cache_attr;
    logic [7:0]  space_identifier;
    logic [63:0] addr;
    segment_e    segment;
    mode_e       mode;
  } xlate_res_s;

endpackage

// ### hw/privileged_address_segment_decoder.sv
// Notes on behaviour
// - Supervisor when privilege field is 01 and both level bits are clear.
// - Supervisor wide bit picks 32 or 64-bit segments and refill handler.
// - Supervisor references go through the TLB; cacheability from the TLB entry.
// - 32-bit mode: bits 63-32 must copy bit 31, else address error.
// - Supervisor 32-bit, bit 31 clear: mapped 2 GB user segment with space id.
// - Supervisor 32-bit, top bits 110: mapped 512 MB supervisor segment.
// - Supervisor 64-bit, bits 63-62 00: mapped 1 TB user segment.
// - Supervisor 64-bit, bits 63-62 01: mapped 1 TB supervisor segment.
// - Supervisor 64-bit, bits 63-62 11: separate supervisor segment, mapped.
// - Kernel when privilege field 00 or either level bit set.
// - Kernel wide bit picks 32 or 64-bit kernel segments and refill handler.
// - Exceptions force kernel; exception return clears level bit, restoring mode.
// - Kernel 32-bit, bit 31 clear: mapped 2 GB kernel user segment.
// - Error level set turns the low 2 GB of kernel user segment unmapped, uncached, identity.
// - Kernel top bits 100: unmapped, minus 0x80000000, configured cache attribute.
// - Kernel top bits 101: 512 MB uncached direct segment.
// - Kernel top bits 110 and 111: supervisor and mapped kernel segments.
// - 0xFF000000-0xFF3FFFFF and 64-bit counterpart are unmapped, uncached.
// - Uncached direct segment bypasses TLB, address minus 0xA0000000.
// - Top bits 110, and 111 outside the debug range, go through TLB with space id appended.
`timescale 1ns/100ps
`default_nettype none

module privileged_address_segment_decoder (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // Avalon-MM register slave
  input  wire logic [3:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  // Pipeline events
  input  wire logic                       exception_event,
  input  wire logic                       exception_return,
  // Translation request and result
  input  wire seg_decode_pkg::xlate_req_s xlate_req,
  output seg_decode_pkg::xlate_res_s      xlate_res
);

  logic        rst_meta_q;
  logic        rst_sync_q;
  logic [1:0]  priv_q;
  logic        exl_q;
  logic        erl_q;
  logic        swide_q;
  logic        kwide_q;
  logic [7:0]  space_q;
  logic [2:0]  k0_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        acc_go;
  logic        wr_lane0;
  seg_decode_pkg::xlate_res_s res_d;
  seg_decode_pkg::xlate_res_s res_q;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Access completes on the cycle waitrequest is low
  assign acc_go   = (avs_read || avs_write) && !wait_q;
  assign wr_lane0 = acc_go && avs_write && avs_byteenable[0];

  // Fresh copy of a 32-bit kernel-style decode of the low word
  function automatic seg_decode_pkg::xlate_res_s kern32(input logic [63:0] va,
                                                       input logic error_level_bit,
                                                       input logic [2:0] k0);
    seg_decode_pkg::xlate_res_s r;
    r = '0;
    r.mapped         = 1'b1;
    r.cache_from_tlb = 1'b1;
    r.addr           = va;
    if (!va[31]) begin
      r.segment = seg_decode_pkg::SEG_KUSEG;
      if (error_level_bit) begin
        r.mapped         = 1'b0;
        r.cache_from_tlb = 1'b0;
        r.cache_attr     = seg_decode_pkg::CACHE_UNCACHED;
        r.addr           = {32'h0000_0000, va[31:0]};
      end
    end else begin
      case (va[30:29])
        2'b00: begin
          r.segment        = seg_decode_pkg::SEG_KDIRC;
          r.mapped         = 1'b0;
          r.cache_from_tlb = 1'b0;
          r.cache_attr     = k0;
          r.addr           = {32'h0000_0000, va[31:0] - seg_decode_pkg::DIRECT_CACHED_KERNEL_SEGMENT_BASE};
        end
        2'b01: begin
          r.segment        = seg_decode_pkg::SEG_KDIRU;
          r.mapped         = 1'b0;
          r.cache_from_tlb = 1'b0;
          r.cache_attr     = seg_decode_pkg::CACHE_UNCACHED;
          r.addr           = {32'h0000_0000, va[31:0] - seg_decode_pkg::UNCACHED_DIRECT_KERNEL_SEGMENT_BASE};
        end
        2'b10: begin
          r.segment = seg_decode_pkg::SEG_KSSEG;
        end
        default: begin
          if (va[31:22] == seg_decode_pkg::DEBUG_TOP10) begin
            r.segment        = seg_decode_pkg::SEG_DEBUG;
            r.mapped         = 1'b0;
            r.cache_from_tlb = 1'b0;
            r.cache_attr     = seg_decode_pkg::CACHE_UNCACHED;
            r.addr           = {32'h0000_0000, va[31:0]};
          end else begin
            r.segment = seg_decode_pkg::SEG_KMAP;
          end
        end
      endcase
    end
    return r;
  endfunction

  // 32-bit sign extension check
  function automatic logic sext_bad(input logic [63:0] va);
    return va[63:32] != {32{va[31]}};
  endfunction

  // Mode selection and segment decode
  always_comb begin
    logic kern;
    logic sup_mode;
    logic [63:0] va;
    kern     = (priv_q == seg_decode_pkg::PRIV_KERNEL) || exl_q || erl_q;
    sup_mode = (priv_q == seg_decode_pkg::PRIV_SUPER) && !exl_q && !erl_q;
    va    = xlate_req.vaddr;
    res_d = '0;
    res_d.addr           = va;
    res_d.mapped         = 1'b1;
    res_d.cache_from_tlb = 1'b1;
    if (kern) begin
      res_d.mode = seg_decode_pkg::MODE_KERNEL;
      if (!kwide_q) begin
        res_d             = kern32(va, erl_q, k0_q);
        res_d.addr_error  = sext_bad(va);
      end else begin
        res_d.wide_refill = 1'b1;
        case (va[63:62])
          2'b00: begin
            res_d.segment = seg_decode_pkg::SEG_KUSEG;
            if (erl_q && va[61:31] == '0) begin
              res_d.mapped         = 1'b0;
              res_d.cache_from_tlb = 1'b0;
              res_d.cache_attr     = seg_decode_pkg::CACHE_UNCACHED;
            end
          end
          2'b01: res_d.segment = seg_decode_pkg::SEG_XKMAP;
          2'b10: begin
            res_d.segment        = seg_decode_pkg::SEG_XKPHYS;
            res_d.mapped         = 1'b0;
            res_d.cache_from_tlb = 1'b0;
            res_d.cache_attr     = va[61:59];
            res_d.addr           = {28'h000_0000, va[35:0]};
            res_d.addr_error     = va[58:36] != '0;
          end
          default: begin
            if (va[61:31] == ONES31()) begin
              res_d             = kern32(va, 1'b0, k0_q);
              res_d.wide_refill = 1'b1;
            end else begin
              res_d.segment = seg_decode_pkg::SEG_XKMAP;
            end
          end
        endcase
        res_d.mode = seg_decode_pkg::MODE_KERNEL;
      end
      res_d.mode = seg_decode_pkg::MODE_KERNEL;
    end else if (sup_mode) begin
      res_d.mode = seg_decode_pkg::MODE_SUPER;
      if (!swide_q) begin
        res_d.addr_error = sext_bad(va);
        if (!va[31]) begin
          res_d.segment = seg_decode_pkg::SEG_SUSEG;
        end else if (va[30:29] == 2'b10) begin
          res_d.segment = seg_decode_pkg::SEG_SSEG;
        end else begin
          res_d.addr_error = 1'b1;
        end
      end else begin
        res_d.wide_refill = 1'b1;
        case (va[63:62])
          2'b00: begin
            res_d.segment    = seg_decode_pkg::SEG_XSUSEG;
            res_d.addr_error = va[61:40] != '0;
          end
          2'b01: begin
            res_d.segment    = seg_decode_pkg::SEG_XSSEG;
            res_d.addr_error = va[61:40] != '0;
          end
          2'b11: begin
            res_d.segment    = seg_decode_pkg::SEG_CSSEG;
            res_d.addr_error = va[63:29] != seg_decode_pkg::CSSEG_TOP35;
          end
          default: res_d.addr_error = 1'b1;
        endcase
      end
    end else begin
      res_d.mode = seg_decode_pkg::MODE_USER;
      res_d.segment    = seg_decode_pkg::SEG_USEG;
      res_d.addr_error = sext_bad(va) || va[31];
    end
    res_d.space_identifier = res_d.mapped ? space_q : 8'h00;
    if (res_d.addr_error) begin
      res_d.mapped         = 1'b0;
      res_d.cache_from_tlb = 1'b0;
    end
    res_d.valid = xlate_req.valid;
  end

  // All ones for bits 61..31
  function automatic logic [30:0] ONES31();
    return seg_decode_pkg::ONES32[30:0];
  endfunction

  // Translation result register
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  // Privilege level, width bits and exception levels
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      priv_q  <= seg_decode_pkg::RST_PRIV;
      exl_q   <= seg_decode_pkg::RST_EXL;
      erl_q   <= seg_decode_pkg::RST_ERL;
      swide_q <= seg_decode_pkg::RST_SWIDE;
      kwide_q <= seg_decode_pkg::RST_KWIDE;
    end else begin
      if (wr_lane0 && avs_address == seg_decode_pkg::OFS_STATUS) begin
        priv_q  <= avs_writedata[seg_decode_pkg::POS_PRIV +: 2];
        exl_q   <= avs_writedata[seg_decode_pkg::POS_EXL];
        erl_q   <= avs_writedata[seg_decode_pkg::POS_ERL];
        swide_q <= avs_writedata[seg_decode_pkg::POS_SWIDE];
        kwide_q <= avs_writedata[seg_decode_pkg::POS_KWIDE];
      end
      if (exception_return) begin
        if (erl_q) begin
          erl_q <= 1'b0;
        end else begin
          exl_q <= 1'b0;
        end
      end
      if (exception_event) begin
        exl_q <= 1'b1;
      end
    end
  end

  // Space identifier and unmapped cache attribute
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      space_q <= seg_decode_pkg::RST_SPACE;
      k0_q    <= seg_decode_pkg::RST_K0;
    end else begin
      if (wr_lane0 && avs_address == seg_decode_pkg::OFS_SPACE) begin
        space_q <= avs_writedata[7:0];
      end
      if (wr_lane0 && avs_address == seg_decode_pkg::OFS_CONFIG) begin
        k0_q <= avs_writedata[2:0];
      end
    end
  end

  // Bus handshake: one wait cycle, then completion
  always_ff @(posedge mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if ((avs_read || avs_write) && wait_q) begin
        case (avs_address)
          seg_decode_pkg::OFS_STATUS:
            rdata_q <= {24'h00_0000, kwide_q, 1'b0, swide_q, priv_q, erl_q, exl_q, 1'b0};
          seg_decode_pkg::OFS_SPACE:  rdata_q <= {24'h00_0000, space_q};
          seg_decode_pkg::OFS_CONFIG: rdata_q <= {29'h0000_0000, k0_q};
          seg_decode_pkg::OFS_RESULT:
            rdata_q <= {22'h00_0000, res_q.mode, res_q.addr_error, res_q.mapped,
                        res_q.wide_refill, res_q.valid, res_q.segment};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign xlate_res       = res_q;

endmodule

`default_nettype wire

// ### bench/pipeline_model.sv
`timescale 1ns/100ps
`default_nettype none

// Pipeline side: issues addresses and exception events
module pipeline_model (
  input  wire logic                  mclk,
  output seg_decode_pkg::xlate_req_s req,
  output logic                       exc,
  output logic                       exception_return_instruction
);
  initial begin
    req = '0;
    exc = 1'b0;
    exception_return_instruction = 1'b0;
  end

  // One request for one cycle, then the address bus shows junk
  task automatic issue(input logic [63:0] va);
    @(posedge mclk);
    req <= '{valid: 1'b1, vaddr: va};
    @(posedge mclk);
    req <= '{valid: 1'b0, vaddr: ~va};
  endtask

  // One-cycle event pulse, 1 for exception, 0 for return
  task automatic pulse(input logic kind);
    @(posedge mclk);
    exc <= kind;
    exception_return_instruction <= ~kind;
    @(posedge mclk);
    exc <= 1'b0;
    exception_return_instruction <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### bench/privileged_address_segment_decoder_assertions.sv
`timescale 1ns/100ps
`default_nettype none

// Bus and decode checks at the decoder ports
module privileged_address_segment_decoder_assertions (
  input wire logic                       mclk,
  input wire logic                       rst_n,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic                       avs_waitrequest,
  input wire logic                       exception_event,
  input wire seg_decode_pkg::xlate_req_s xlate_req,
  input wire seg_decode_pkg::xlate_res_s xlate_res
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_exc_req;
    exception_event ##1 1'b1;
  endsequence

  property p_bus_ans;
    s_bus_req |=> !avs_waitrequest;
  endproperty
  property p_res_valid;
    xlate_req.valid |=> xlate_res.valid;
  endproperty
  property p_sign;
    xlate_res.valid && !xlate_res.wide_refill
      && $past(xlate_req.vaddr[63:32]) != {32{$past(xlate_req.vaddr[31])}}
      |-> xlate_res.addr_error;
  endproperty
  property p_kdirc;
    xlate_res.valid && xlate_res.segment == seg_decode_pkg::SEG_KDIRC |-> !xlate_res.mapped
      && xlate_res.addr[31:0] == $past(xlate_req.vaddr[31:0]) - seg_decode_pkg::DIRECT_CACHED_KERNEL_SEGMENT_BASE;
  endproperty
  property p_kdiru;
    xlate_res.valid && xlate_res.segment == seg_decode_pkg::SEG_KDIRU |-> !xlate_res.mapped
      && xlate_res.cache_attr == seg_decode_pkg::CACHE_UNCACHED
      && xlate_res.addr[31:0] == $past(xlate_req.vaddr[31:0]) - seg_decode_pkg::UNCACHED_DIRECT_KERNEL_SEGMENT_BASE;
  endproperty
  property p_debug;
    xlate_res.valid && xlate_res.mode == seg_decode_pkg::MODE_KERNEL
      && $past(xlate_req.vaddr[63:22]) == {seg_decode_pkg::ONES32, seg_decode_pkg::DEBUG_TOP10}
      |-> xlate_res.segment == seg_decode_pkg::SEG_DEBUG && !xlate_res.mapped;
  endproperty
  property p_super_tlb;
    xlate_res.valid && xlate_res.mode == seg_decode_pkg::MODE_SUPER && !xlate_res.addr_error
      |-> xlate_res.mapped && xlate_res.cache_from_tlb;
  endproperty
  property p_err_nomap;
    xlate_res.valid && xlate_res.addr_error |-> !xlate_res.mapped;
  endproperty
  property p_exc_kernel;
    s_exc_req |=> xlate_res.mode == seg_decode_pkg::MODE_KERNEL;
  endproperty

  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
  a_res_valid: assert property (p_res_valid) else $error("result missing");
  a_sign: assert property (p_sign) else $error("sign fault passed");
  a_kdirc: assert property (p_kdirc) else $error("cached direct wrong");
  a_kdiru: assert property (p_kdiru) else $error("uncached direct wrong");
  a_debug: assert property (p_debug) else $error("debug range wrong");
  a_super_tlb: assert property (p_super_tlb) else $error("super not mapped");
  a_err_nomap: assert property (p_err_nomap) else $error("error yet mapped");
  a_exc_kernel: assert property (p_exc_kernel) else $error("no kernel");
endmodule

bind privileged_address_segment_decoder privileged_address_segment_decoder_assertions
  privileged_address_segment_decoder_assertions_inst (
  .mclk            (mclk),
  .rst_n           (rst_n),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_waitrequest (avs_waitrequest),
  .exception_event (exception_event),
  .xlate_req       (xlate_req),
  .xlate_res       (xlate_res)
);

`default_nettype wire

// ### bench/privileged_address_segment_decoder_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module privileged_address_segment_decoder_tb_top;
  logic                       mclk;
  logic                       rst_n;
  logic [3:0]                 avs_address;
  logic                       avs_read;
  logic                       avs_write;
  logic [31:0]                avs_writedata;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic                       exception_event;
  logic                       exception_return;
  seg_decode_pkg::xlate_req_s xlate_req;
  seg_decode_pkg::xlate_res_s xlate_res;
  seg_decode_pkg::xlate_res_s xq[$];
  seg_decode_pkg::xlate_res_s x;
  logic [31:0]                rq[$];
  logic [7:0]                 st;
  logic [7:0]                 sid;
  logic [15:0]                lf;
  int                         fail_count;
  int                         tests_run;
  int                         cyc;

  privileged_address_segment_decoder privileged_address_segment_decoder_inst (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .exception_event(exception_event), .exception_return(exception_return),
    .xlate_req(xlate_req), .xlate_res(xlate_res));
  pipeline_model pipeline_model_inst (
    .mclk(mclk), .req(xlate_req), .exc(exception_event), .exception_return_instruction(exception_return));

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Bus request held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_read <= rd;
    avs_write <= ~rd;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b1, a, 32'h0000_0000);
  endtask
  task automatic ws(input logic [7:0] v);
    st = v;
    bus(1'b0, seg_decode_pkg::OFS_STATUS, {24'h00_0000, v});
  endtask

  // Note the expected decode, then issue the address
  task automatic tr(input logic [63:0] va, input seg_decode_pkg::segment_e sg,
                    input logic er, input logic mp, input logic [2:0] ca);
    logic k;
    k = st[1] | st[2] | (st[4:3] == 2'h0);
    x = '0;
    x.addr_error = er;
    x.mapped = mp;
    x.mode = k ? seg_decode_pkg::MODE_KERNEL : seg_decode_pkg::MODE_SUPER;
    x.wide_refill = k ? st[7] : st[5];
    x.space_identifier = mp ? sid : 8'h00;
    x.cache_attr = ca;
    x.segment = sg;
    x.addr = va - (sg == seg_decode_pkg::SEG_KDIRC ? 64'h8000_0000 :
                   sg == seg_decode_pkg::SEG_KDIRU ? 64'hA000_0000 : 64'h0000_0000);
    xq.push_back(x);
    pipeline_model_inst.issue(va);
  endtask

  // Match each result against the oldest note
  always @(negedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      chk("readdata", rq.pop_front(), avs_readdata);
    end
    if (xlate_res.valid === 1'b1) begin
      x = xq.pop_front();
      chk("error", x.addr_error, xlate_res.addr_error);
      chk("mode", x.mode, xlate_res.mode);
      if (!x.addr_error) begin
        chk("mapped", x.mapped, xlate_res.mapped);
        chk("wide", x.wide_refill, xlate_res.wide_refill);
        chk("space", x.space_identifier, xlate_res.space_identifier);
        if (x.segment != seg_decode_pkg::SEG_NONE) begin
          chk("segment", x.segment, xlate_res.segment);
        end
        if (x.mapped) begin
          chk("tlbcache", 1'b1, xlate_res.cache_from_tlb);
        end else begin
          chk("attr", x.cache_attr, xlate_res.cache_attr);
          chk("paddr", x.addr[31:0], xlate_res.addr[31:0]);
        end
      end
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    st = 8'h04;
    sid = 8'h00;
    lf = 16'h004A;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(seg_decode_pkg::OFS_STATUS, 32'h0000_0004);
    rd(seg_decode_pkg::OFS_SPACE, 32'h0000_0000);
    rd(seg_decode_pkg::OFS_CONFIG, 32'h0000_0002);
    rd(4'h1, 32'h0000_0000);
    bus(1'b0, seg_decode_pkg::OFS_SPACE, 32'h0000_00A5);
    sid = 8'hA5;
    bus(1'b0, seg_decode_pkg::OFS_CONFIG, 32'h0000_0005);
    tr(64'h0000_0000_0000_1000, seg_decode_pkg::SEG_KUSEG, 1'b0, 1'b0, 3'h2);
    ws(8'h00);
    tr(64'h0000_0000_7FFF_FFFF, seg_decode_pkg::SEG_KUSEG, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_8000_0010, seg_decode_pkg::SEG_KDIRC, 1'b0, 1'b0, 3'h5);
    tr(64'hFFFF_FFFF_BFFF_FFFF, seg_decode_pkg::SEG_KDIRU, 1'b0, 1'b0, 3'h2);
    tr(64'hFFFF_FFFF_C000_0000, seg_decode_pkg::SEG_KSSEG, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_FEFF_FFFF, seg_decode_pkg::SEG_KMAP, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_FF3F_FFFF, seg_decode_pkg::SEG_DEBUG, 1'b0, 1'b0, 3'h2);
    tr(64'h0000_0000_8000_0000, seg_decode_pkg::SEG_NONE, 1'b1, 1'b0, 3'h0);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      tr({32'hFFFF_FFFF, 2'b10, i[0], lf, lf[12:0]},
         i[0] ? seg_decode_pkg::SEG_KDIRU : seg_decode_pkg::SEG_KDIRC,
         1'b0, 1'b0, i[0] ? 3'h2 : 3'h5);
    end
    ws(8'h80);
    tr(64'h4000_0000_0000_0000, seg_decode_pkg::SEG_NONE, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_FF00_0000, seg_decode_pkg::SEG_DEBUG, 1'b0, 1'b0, 3'h2);
    ws(8'h08);
    tr(64'h0000_0000_1234_5678, seg_decode_pkg::SEG_SUSEG, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_C000_0000, seg_decode_pkg::SEG_SSEG, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_8000_0000, seg_decode_pkg::SEG_NONE, 1'b1, 1'b0, 3'h0);
    tr(64'h0000_0001_0000_0000, seg_decode_pkg::SEG_NONE, 1'b1, 1'b0, 3'h0);
    pipeline_model_inst.pulse(1'b1);
    st[1] = 1'b1;
    rd(seg_decode_pkg::OFS_STATUS, 32'h0000_000A);
    tr(64'hFFFF_FFFF_8000_0000, seg_decode_pkg::SEG_KDIRC, 1'b0, 1'b0, 3'h5);
    pipeline_model_inst.pulse(1'b0);
    st[1] = 1'b0;
    tr(64'hFFFF_FFFF_8000_0000, seg_decode_pkg::SEG_NONE, 1'b1, 1'b0, 3'h0);
    ws(8'h0C);
    tr(64'hFFFF_FFFF_8000_0000, seg_decode_pkg::SEG_KDIRC, 1'b0, 1'b0, 3'h5);
    ws(8'h28);
    tr(64'h0000_00FF_FFFF_FFFF, seg_decode_pkg::SEG_XSUSEG, 1'b0, 1'b1, 3'h0);
    tr(64'h4000_00FF_FFFF_FFFF, seg_decode_pkg::SEG_XSSEG, 1'b0, 1'b1, 3'h0);
    tr(64'hFFFF_FFFF_DFFF_FFFF, seg_decode_pkg::SEG_CSSEG, 1'b0, 1'b1, 3'h0);
    tr(64'h0000_0100_0000_0000, seg_decode_pkg::SEG_NONE, 1'b1, 1'b0, 3'h0);
    repeat (4) @(posedge mclk);
    chk("pending", 64'h0000_0000_0000_0000, xq.size());
    test_done();
  end
endmodule

`default_nettype wire
